// ---- dprq_top.v ----
// device-side request service for one dma channel: request select, single transfer, end-of-transfer
// assumes peripherals keep their own enables and hold each request until acknowledged
// limitation: one channel only; arbitration, address pointers and circular mode live elsewhere
// trade-off: requests pass two sync flops, so each transfer starts two cycles late
//
// Operation
// - cipher channel always moves exactly one byte per transfer
// - cipher input channel runs memory to peripheral, direction one
// - cipher output channel runs peripheral to memory, direction zero
// - count reached: end-of-transfer pulse to two-wire plus interrupt
// - two-wire master receive: early end-of-transfer at count minus one
// - channel requests are ORed, only one source enabled at once
`timescale 1ns/1ps
`include "dprq_consts.vh"

module dprq_top #(
    parameter NSRC = 8,
    parameter CW = 16
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_channel_enable,
    input wire [CW-1:0] i_transfer_count,
    input wire i_cipher_input_sel,
    input wire i_cipher_output_sel,
    input wire i_two_wire_sel,
    input wire i_two_wire_master_rx,
    input wire i_dir_cfg,
    input wire [NSRC-1:0] i_src_req,
    input wire i_xfer_done,
    output wire o_xfer_req,
    output reg o_channel_transfer_direction,
    output reg o_transfer_size,
    output reg [NSRC-1:0] o_src_ack,
    output reg o_end_of_transfer_signal,
    output reg o_early_end_of_transfer_signal,
    output reg o_dma_irq,
    output reg o_busy,
    output reg o_multi_source_err,
    output reg [CW-1:0] o_done_count
);

// ----------------------------------------
// request input synchronisers
// ----------------------------------------
// pins come from other peripheral timing, so two flops each
reg [NSRC-1:0] req_s1_q;
reg [NSRC-1:0] req_s2_q;
reg busy_q;
reg [CW-1:0] cnt_q;
wire any_req;
wire multi_req;
wire run;
wire [CW-1:0] early_cnt;
reg dir_d;
reg busy_d;
reg [CW-1:0] cnt_d;
reg [NSRC-1:0] ack_d;
reg eot_d;
reg early_d;
reg irq_d;
wire done_now;
wire last_hit;
wire early_hit;

// ----------------------------------------
// helper functions
// ----------------------------------------
// count after one more transfer, shared by the end and early end compares
function [CW-1:0] next_count;
    input [CW-1:0] cur;
    begin
        next_count = cur + {{(CW-1){1'b0}}, 1'b1};
    end
endfunction

genvar g;
generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_sync
        always @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                req_s1_q[g] <= 1'h0;
                req_s2_q[g] <= 1'h0;
            end else begin
                req_s1_q[g] <= i_src_req[g];
                req_s2_q[g] <= req_s1_q[g];
            end
        end
    end
endgenerate

// ----------------------------------------
// request combining
// ----------------------------------------
assign any_req = |req_s2_q;
// more than one bit set: x & (x-1) nonzero
assign multi_req = |(req_s2_q & (req_s2_q - {{(NSRC-1){1'b0}}, 1'b1}));
assign run = i_channel_enable && (cnt_q != i_transfer_count);
// one request at a time; a fresh one only after the ack drops and resynchronises
assign o_xfer_req = run && any_req && !busy_q && (o_src_ack == {NSRC{1'b0}});
assign early_cnt = i_transfer_count - `DPRQ_EARLY_OFFSET;
// o_xfer_req needs busy low, so a done pulse never meets a fresh request
assign done_now = busy_q && i_xfer_done;
assign last_hit = (next_count(cnt_q) == i_transfer_count);
assign early_hit = (next_count(cnt_q) == early_cnt);

// ----------------------------------------
// direction, next value
// ----------------------------------------
// cipher input wins when both cipher selects are set
always @* begin
    dir_d = i_dir_cfg;
    if (i_cipher_input_sel) begin
        dir_d = `DPRQ_DIR_MEM2PER;
    end else if (i_cipher_output_sel) begin
        dir_d = `DPRQ_DIR_PER2MEM;
    end
end

// ----------------------------------------
// direction and size registers
// ----------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_channel_transfer_direction <= `DPRQ_DIR_PER2MEM;
        o_transfer_size <= `DPRQ_SIZE_BYTE;
    end else begin
        o_channel_transfer_direction <= dir_d;
        o_transfer_size <= `DPRQ_SIZE_BYTE;
    end
end

// ----------------------------------------
// transfer sequencing, next values
// ----------------------------------------
// ack held until the source drops its request
always @* begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    ack_d = o_src_ack & req_s2_q;
    eot_d = 1'h0;
    early_d = 1'h0;
    irq_d = 1'h0;
    if (!i_channel_enable) begin
        cnt_d = `DPRQ_CNT_RST;
    end
    if (o_xfer_req) begin
        busy_d = 1'h1;
    end else if (done_now) begin
        busy_d = 1'h0;
        ack_d = req_s2_q;
        cnt_d = next_count(cnt_q);
        if (last_hit) begin
            eot_d = i_two_wire_sel;
            irq_d = 1'h1;
        end
        if (i_two_wire_sel && i_two_wire_master_rx && early_hit) begin
            early_d = 1'h1;
        end
    end
end

// ----------------------------------------
// transfer sequencing registers
// ----------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        busy_q <= 1'h0;
        cnt_q <= `DPRQ_CNT_RST;
        o_src_ack <= {NSRC{1'b0}};
        o_end_of_transfer_signal <= 1'h0;
        o_early_end_of_transfer_signal <= 1'h0;
        o_dma_irq <= 1'h0;
    end else begin
        busy_q <= busy_d;
        cnt_q <= cnt_d;
        o_src_ack <= ack_d;
        o_end_of_transfer_signal <= eot_d;
        o_early_end_of_transfer_signal <= early_d;
        o_dma_irq <= irq_d;
    end
end

// ----------------------------------------
// status registers
// ----------------------------------------
// status trails the working state by one cycle
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_busy <= 1'h0;
        o_multi_source_err <= 1'h0;
        o_done_count <= `DPRQ_CNT_RST;
    end else begin
        o_busy <= busy_q;
        o_multi_source_err <= multi_req && i_channel_enable;
        o_done_count <= cnt_q;
    end
end

endmodule // dprq_top

// ---- dprq_consts.vh ----
// dma request service constants: direction codes, transfer size, end-of-transfer offset
// assumes inclusion by dprq_top.v only
`ifndef DPRQ_CONSTS_VH
`define DPRQ_CONSTS_VH
`define DPRQ_DIR_MEM2PER 1'h1
`define DPRQ_DIR_PER2MEM 1'h0
`define DPRQ_SIZE_BYTE 1'h0
`define DPRQ_EARLY_OFFSET 16'h0001
`define DPRQ_CNT_RST 16'h0000
`define DPRQ_SYNC_RST 2'h0
`endif

// ---- dprq_checker.sv ----
// checker of channel request service; bound onto dprq_top, one clock
`timescale 1ns/1ps
module dprq_checker #(parameter NSRC = 8) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_cipher_input_sel,
    input wire i_cipher_output_sel,
    input wire i_xfer_done,
    input wire o_busy,
    input wire o_channel_transfer_direction,
    input wire o_transfer_size,
    input wire [NSRC-1:0] o_src_ack,
    input wire o_end_of_transfer_signal,
    input wire o_early_end_of_transfer_signal,
    input wire o_dma_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_cin; (o_busy && i_cipher_input_sel) [*2]; endsequence
    a_size_byte: assert property (!o_transfer_size) else $error("size");
    a_dir_cin: assert property (s_cin |-> o_channel_transfer_direction) else $error("dir in");
    a_dir_cout: assert property ((o_busy && !i_cipher_input_sel && i_cipher_output_sel) [*2]
        |-> !o_channel_transfer_direction) else $error("dir out");
    a_eot_irq: assert property (o_end_of_transfer_signal |-> o_dma_irq ##1 !o_dma_irq) else $error("eot");
    a_early_eot: assert property (o_early_end_of_transfer_signal |-> !o_end_of_transfer_signal) else $error("early");
    a_ack_done: assert property ($rose(|o_src_ack) |-> $past(i_xfer_done)) else $error("ack");
    a_ack_one: assert property ($onehot0(o_src_ack)) else $error("multi");
endmodule // dprq_checker
bind dprq_top dprq_checker #(.NSRC(NSRC)) u_chk (.*);

// ---- dprq_periph.sv ----
// peripheral model, request held until acked; assumes the channel clock
`timescale 1ns/1ps
module dprq_periph (
    input wire i_clk,
    input wire i_nrst,
    input wire [7:0] i_trig,
    input wire [7:0] i_en,
    input wire [7:0] i_ack,
    input wire i_eot,
    input wire i_early_eot,
    output reg [7:0] o_req
);
    // bits: 0 cipher 1 cipher out 2 serial rx 3 serial tx
    // 4 two-wire data register 5 converter trigger 6 timer update
    // 7 timer capture/compare or commutation
    reg tw_en_q;
    reg tw_last_q;
    always @(posedge i_clk or negedge i_nrst)
        if (!i_nrst) begin
            tw_en_q <= 1'b1;
            tw_last_q <= 1'b0;
        end else begin
            if (i_early_eot) tw_last_q <= 1'b1;
            if (i_eot || (tw_last_q && i_ack[4])) tw_en_q <= 1'b0;
        end
    always @(posedge i_clk or negedge i_nrst)
        if (!i_nrst) o_req <= 8'h00;
        else o_req <= (o_req | (i_trig & i_en & {3'h7, tw_en_q, 4'hF})) & ~i_ack;
endmodule // dprq_periph

// ---- dma_peripheral_request_sources_bench.sv ----
// bench driving one channel through a peripheral model; assumes dprq_top, checker, model
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
module dma_peripheral_request_sources_bench;
    reg i_clk = 0, i_nrst = 0, i_channel_enable = 1, i_cipher_input_sel = 1, i_cipher_output_sel = 1;
    reg i_two_wire_sel = 1, i_two_wire_master_rx = 1, i_dir_cfg = 1, i_xfer_done = 0;
    reg [15:0] i_transfer_count = 16'h0002;
    reg [7:0] trig = 8'h00;
    reg [7:0] en = 8'hFF;
    wire [7:0] i_src_req, o_src_ack;
    wire [15:0] o_done_count;
    wire o_xfer_req, o_channel_transfer_direction, o_transfer_size, o_end_of_transfer_signal;
    wire o_early_end_of_transfer_signal, o_dma_irq, o_busy, o_multi_source_err;
    integer mismatches = 0, check_count = 0, n;
    dprq_top DUT (.*);
    dprq_periph peer (.i_clk, .i_nrst, .i_trig(trig), .i_en(en), .i_ack(o_src_ack),
        .i_eot(o_end_of_transfer_signal), .i_early_eot(o_early_end_of_transfer_signal), .o_req(i_src_req));
    always #12.5 i_clk = ~i_clk;
    task finish_test;
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task serve(input [7:0] t, input e, input x, input d);
        trig = t;
        @(negedge i_clk) trig = 8'h00;
        for (n = 0; n < 20 && o_busy !== 1'b1; n++) @(negedge i_clk);
        i_xfer_done = 1;
        @(negedge i_clk) i_xfer_done = 0;
        `CHK({o_src_ack, o_end_of_transfer_signal, o_early_end_of_transfer_signal, o_dma_irq, o_channel_transfer_direction}, {t, e, x, e, d})
        repeat (8) @(negedge i_clk);
    endtask
    initial begin
        repeat (3) @(negedge i_clk);
        i_nrst = 1;
        serve(8'h01, 0, 1, 1);
        i_cipher_input_sel = 0;
        serve(8'h04, 1, 0, 0);
        `CHK({o_transfer_size, o_done_count}, 17'h00002)
        trig = 8'h60;
        repeat (6) @(negedge i_clk);
        `CHK({o_xfer_req, o_multi_source_err}, 2'h1)
        finish_test;
    end
    initial begin
        #20000 mismatches++;
        finish_test;
    end
endmodule // dma_peripheral_request_sources_bench
